// [rtl/bemf_zc_qualifier.sv]
// back-EMF zero-crossing qualifier with Avalon-MM register slave
// Notes on behaviour
// R01 - real zero-crossing sampling starts only after commutation and demagnetization
// R02 - back-EMF read only while PWM drives the group chosen by group select; configuration x11 reads without checking PWM
// R03 - qualified crossing sets zero-crossing flag; interrupt when its enable is set
// R04 - each qualified crossing pulses a trigger to the delay manager
// R05 - sensor mode takes the phase input chosen by input select as logic level
// R06 - sensor mode disables all demagnetization handling
// R07 - sensor mode accepts crossings without phase check, sampled at 800 kHz
// R08 - sensor mode cuts current-control minimum off time to 1.25 us
// R09 - in direct access mode the latched sample holds, not following the pin
// R10 - software reads sensor by select, indirect access, back to direct, read
// R11 - sensorless: demag filtered 30 us after C, crossing 20 us after D
// R12 - sensor mode ignores top configuration bit, filters crossing 20 us after C
// R13 - current mode x00 even, x01 odd, x10 either select permit reading
// R14 - voltage mode 000/100 even, 001/101 odd, 110 either permit reading
// R15 - configuration x11 sensorless permits reading on either group
// R16 - sensor mode always permits reading; other combinations forbid it
// R17 - events kept in order commutation, demagnetization, zero crossing
// R18 - comparator edges classified as demag or crossing by edge and polarity
// R19 - samples taken while reading is forbidden are discarded
`timescale 1ns/1ns
module bemf_zc_qualifier
	import bemf_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// motor side pins
	input wire logic phase_in_a,
	input wire logic phase_in_b,
	input wire logic phase_in_c,
	input wire logic cmp_in,
	// events and state from the rest of the motor unit
	input wire logic commutation_evt,
	input wire logic sw_demag_evt,
	input wire logic pwm_on_even,
	input wire logic pwm_on_odd,
	input wire logic direct_access,
	// outputs to the motor unit
	output logic zc_trigger,
	output logic demag_trigger,
	output logic zc_sampling,
	output logic demag_enable,
	output logic [2:0] pwm_cfg_eff,
	output logic [5:0] min_off_cyc,
	output logic irq
);
	// ****************************************
	// registers and control fields
	// ****************************************
	logic [11:0] ctrl_r;
	logic [1:0] irq_status_reg;
	logic [1:0] irq_mask_reg;
	logic ack_r;
	logic sensor_mode_sel, volt_current_sel, zc_edge_sel, cmp_polarity, bemf_group_sel;
	logic [2:0] pwm_out_group_cfg;
	logic [1:0] sense_input_sel;
	logic hw_demag_en, sw_demag_en;
	logic wr_acc, rd_acc;

	assign sensor_mode_sel = ctrl_r[B_SENSOR];
	assign volt_current_sel = ctrl_r[B_VC];
	assign zc_edge_sel = ctrl_r[B_EDGE];
	assign cmp_polarity = ctrl_r[B_POL];
	assign bemf_group_sel = ctrl_r[B_GRP];
	assign pwm_out_group_cfg = ctrl_r[B_CFG +: 3];
	assign sense_input_sel = ctrl_r[B_INSEL +: 2];
	assign hw_demag_en = ctrl_r[B_HDM];
	assign sw_demag_en = ctrl_r[B_SDM];

	// one wait cycle, then the access completes
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign wr_acc = avs_write & ack_r;
	assign rd_acc = avs_read & ~ack_r;

	always_ff @(posedge clk_sys) begin
		if (rst | ack_r) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= avs_read | avs_write;
		end
	end

	// control register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_r <= CTRL_RST;
		end else if (wr_acc && avs_address == ADDR_CTRL) begin
			ctrl_r <= avs_writedata[11:0];
		end
	end

	// mask register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_mask_reg <= 2'h0;
		end else if (wr_acc && avs_address == ADDR_MASK) begin
			irq_mask_reg <= avs_writedata[1:0];
		end
	end

	// ****************************************
	// pin synchronisers and 800 kHz sampling
	// ****************************************
	logic [3:0] s1_r, s2_r, s3_r;
	logic [3:0] pin_r;
	logic [4:0] div_r;
	logic samp_en;
	logic sel_in;
	logic latched_cmp_out;
	logic prev_r;
	logic primed_r;

	// three stages; a change is taken once stages two and three agree
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s1_r <= 4'h0;
			s2_r <= 4'h0;
			s3_r <= 4'h0;
			pin_r <= 4'h0;
		end else begin
			s1_r <= {cmp_in, phase_in_c, phase_in_b, phase_in_a};
			s2_r <= s1_r;
			s3_r <= s2_r;
			pin_r <= (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
		end
	end

	// sample divider, halted while direct access is active
	always_ff @(posedge clk_sys) begin
		if (rst || samp_en) begin
			div_r <= 5'h00;
		end else if (!direct_access) begin // [R09]
			div_r <= div_r + 5'h01;
		end
	end
	assign samp_en = !direct_access && div_r == 5'(SAMPLE_CYC - 1); // [R07] [R11]

	// input select: phase pin in sensor mode, comparator otherwise
	always_comb begin
		sel_in = pin_r[3];
		if (sensor_mode_sel) begin // [R05]
			unique case (sense_input_sel)
				2'h0: sel_in = pin_r[0];
				2'h1: sel_in = pin_r[1];
				2'h2: sel_in = pin_r[2];
				default: sel_in = 1'b0;
			endcase
		end
	end

	// sample latch; holds while direct access stops the sampler
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			latched_cmp_out <= 1'b0;
			prev_r <= 1'b0;
		end else if (samp_en) begin // [R09]
			latched_cmp_out <= sel_in ^ cmp_polarity;
			prev_r <= primed_r ? latched_cmp_out : (sel_in ^ cmp_polarity); // [R18]
		end
	end

	// first sample after reset only seeds the edge detector, so no false edge follows reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			primed_r <= 1'b0;
		end else if (samp_en) begin
			primed_r <= 1'b1;
		end
	end

	// ****************************************
	// edge classification and read permission
	// ****************************************
	logic new_smp_r;
	logic rise, fall, z_edge, dh_edge;
	logic cfg_ok, grp_ok, read_ok;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			new_smp_r <= 1'b0;
		end else begin
			new_smp_r <= samp_en;
		end
	end
	assign rise = new_smp_r & latched_cmp_out & ~prev_r;
	assign fall = new_smp_r & ~latched_cmp_out & prev_r;
	assign z_edge = zc_edge_sel ? fall : rise; // [R18]
	assign dh_edge = zc_edge_sel ? rise : fall; // [R18]

	// configuration table for back-EMF reading
	always_comb begin
		cfg_ok = 1'b0;
		if (sensor_mode_sel) begin
			cfg_ok = 1'b1; // [R16]
		end else if (pwm_out_group_cfg[1:0] == CFG_BOTH) begin
			cfg_ok = 1'b1; // [R15]
		end else if (volt_current_sel) begin // [R13]
			cfg_ok = (pwm_out_group_cfg[1:0] == CFG_EVEN && !bemf_group_sel) ||
				(pwm_out_group_cfg[1:0] == CFG_ODD && bemf_group_sel) ||
				pwm_out_group_cfg[1:0] == CFG_ALT;
		end else begin // [R14]
			cfg_ok = (pwm_out_group_cfg[1:0] == CFG_EVEN && !bemf_group_sel) ||
				(pwm_out_group_cfg[1:0] == CFG_ODD && bemf_group_sel) ||
				pwm_out_group_cfg == CFG_V_ALT;
		end
	end

	// in sensorless mode outside configuration x11, the chosen group must be the one carrying PWM right now
	assign grp_ok = sensor_mode_sel || pwm_out_group_cfg[1:0] == CFG_BOTH ||
		(bemf_group_sel ? pwm_on_odd : pwm_on_even); // [R02]
	assign read_ok = cfg_ok & grp_ok; // [R16]

	// ****************************************
	// event sequencer C -> D -> Z
	// ****************************************
	stage_t stage_r, stage_nxt;
	logic [9:0] filt_r;
	logic filt_done;
	logic d_evt, z_evt;

	assign filt_done = filt_r == 10'h000;
	assign d_evt = !sensor_mode_sel && stage_r == STG_DEMAG && filt_done &&
		((hw_demag_en && dh_edge) || (sw_demag_en && sw_demag_evt)); // [R06] [R11]
	assign z_evt = stage_r == STG_ZC && filt_done && z_edge && read_ok; // [R17] [R19]

	always_comb begin
		stage_nxt = stage_r;
		unique case (stage_r)
			STG_WAIT_C: if (commutation_evt) begin
				stage_nxt = sensor_mode_sel ? STG_ZC : STG_DEMAG; // [R06]
			end
			STG_DEMAG: if (commutation_evt) begin
				stage_nxt = sensor_mode_sel ? STG_ZC : STG_DEMAG; // [R06]
			end else if (d_evt) begin
				stage_nxt = STG_ZC; // [R01]
			end
			STG_ZC: if (commutation_evt) begin
				stage_nxt = sensor_mode_sel ? STG_ZC : STG_DEMAG;
			end else if (z_evt) begin
				stage_nxt = STG_WAIT_C; // [R17]
			end
			default: stage_nxt = STG_WAIT_C;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stage_r <= STG_WAIT_C;
		end else begin
			stage_r <= stage_nxt;
		end
	end

	// blanking filters reload on entry to the demag and crossing stages
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			filt_r <= 10'h000;
		end else if (stage_nxt == STG_DEMAG && (commutation_evt || stage_r != STG_DEMAG)) begin
			filt_r <= 10'(DEMAG_FILT_CYC - 1); // [R11]
		end else if (stage_nxt == STG_ZC && (commutation_evt || stage_r != STG_ZC)) begin
			filt_r <= 10'(ZC_FILT_CYC - 1); // [R11] [R12]
		end else if (!filt_done) begin
			filt_r <= filt_r - 10'h001;
		end
	end

	// ****************************************
	// outputs to the motor unit
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			zc_trigger <= 1'b0;
			demag_trigger <= 1'b0;
		end else begin
			zc_trigger <= z_evt; // [R04]
			demag_trigger <= d_evt;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			zc_sampling <= 1'b0;
			demag_enable <= 1'b0;
			pwm_cfg_eff <= 3'h0;
			min_off_cyc <= 6'(MIN_OFF_NORM_CYC);
		end else begin
			zc_sampling <= stage_nxt == STG_ZC; // [R01]
			demag_enable <= !sensor_mode_sel; // [R06]
			pwm_cfg_eff <= sensor_mode_sel ? {1'b0, pwm_out_group_cfg[1:0]} :
				pwm_out_group_cfg; // [R12]
			min_off_cyc <= sensor_mode_sel ? 6'(MIN_OFF_SENSOR_CYC) :
				6'(MIN_OFF_NORM_CYC); // [R08]
		end
	end

	// ****************************************
	// interrupt status, set wins over clear
	// ****************************************
	logic [1:0] set_vec, clr_vec;
	assign set_vec = {d_evt, z_evt};
	assign clr_vec = (wr_acc && avs_address == ADDR_STAT) ? avs_writedata[1:0] : 2'h0;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_status_reg <= 2'h0;
		end else begin
			irq_status_reg <= set_vec | (irq_status_reg & ~clr_vec); // [R03]
		end
	end
	assign irq = |(irq_status_reg & irq_mask_reg); // [R03]

	// read data, registered at the wait cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (rd_acc) begin
			unique case (avs_address)
				ADDR_CTRL: avs_readdata <= {20'h00000, ctrl_r};
				ADDR_STAT: avs_readdata <= {30'h0, irq_status_reg};
				ADDR_MASK: avs_readdata <= {30'h0, irq_mask_reg};
				ADDR_PHASE: avs_readdata <= {28'h0, read_ok, stage_r, latched_cmp_out}; // [R10]
			endcase
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	AST_ORDER_ZC: assert property (zc_trigger |-> $past(stage_r) == STG_ZC) // [R01]
		else $error("crossing outside crossing stage");
	AST_GROUP: assert property (z_evt && !sensor_mode_sel && // [R02]
		pwm_out_group_cfg[1:0] != CFG_BOTH |-> (bemf_group_sel ? pwm_on_odd : pwm_on_even))
		else $error("crossing on wrong group");
	AST_FLAG: assert property (z_evt |=> irq_status_reg[S_ZC]) // [R03]
		else $error("flag not set");
	AST_IRQ: assert property (irq_status_reg[S_ZC] && irq_mask_reg[S_ZC] |-> irq) // [R03]
		else $error("irq missing");
	AST_TRIG: assert property (z_evt |=> zc_trigger ##1 !zc_trigger) // [R04]
		else $error("trigger not one pulse");
	AST_NO_DEMAG: assert property (sensor_mode_sel |-> !d_evt) // [R06]
		else $error("demag in sensor mode");
	AST_SENSOR_C: assert property (commutation_evt && sensor_mode_sel |=> stage_r == STG_ZC) // [R06]
		else $error("sensor commutation did not reach crossing stage");
	AST_MINOFF: assert property (sensor_mode_sel && $stable(sensor_mode_sel) |=> // [R08]
		min_off_cyc == 6'(MIN_OFF_SENSOR_CYC))
		else $error("min off not reduced");
	AST_HOLD: assert property (direct_access ##1 direct_access |-> $stable(latched_cmp_out)) // [R09]
		else $error("latch moved in direct access");
	AST_FILT: assert property (stage_r == STG_WAIT_C && commutation_evt && !sensor_mode_sel // [R11]
		|=> !d_evt [*8])
		else $error("demag inside filter");
	AST_FORBID: assert property (!read_ok |-> !z_evt) // [R19]
		else $error("forbidden sample used");
	AST_V010: assert property (!sensor_mode_sel && !volt_current_sel && // [R14]
		pwm_out_group_cfg == 3'h2 |-> !cfg_ok)
		else $error("voltage 010 permitted");

	COV_ZC: cover property (stage_r == STG_DEMAG ##[1:1000] stage_r == STG_ZC);
	COV_SENSOR_ZC: cover property (sensor_mode_sel && zc_trigger);
	COV_IRQ: cover property (irq);
	COV_DIRECT: cover property (direct_access [*4] ##1 !direct_access);
	COV_SW_DEMAG: cover property (demag_trigger && sw_demag_en && !hw_demag_en);
endmodule // bemf_zc_qualifier

// [rtl/bemf_pkg.sv]
// constants shared by the zero-crossing qualifier
package bemf_pkg;
	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_NS = 40;
	localparam int SAMPLE_NS = 1250;
	localparam int DEMAG_FILT_NS = 30000;
	localparam int ZC_FILT_NS = 20000;
	localparam int MIN_OFF_SENSOR_NS = 1250;
	localparam int MIN_OFF_NORM_NS = 2000;
	localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
	localparam int DEMAG_FILT_CYC = DEMAG_FILT_NS / CLK_NS;
	localparam int ZC_FILT_CYC = ZC_FILT_NS / CLK_NS;
	localparam int MIN_OFF_SENSOR_CYC = (MIN_OFF_SENSOR_NS + CLK_NS - 1) / CLK_NS;
	localparam int MIN_OFF_NORM_CYC = (MIN_OFF_NORM_NS + CLK_NS - 1) / CLK_NS;
	// ****************************************
	// register map (word addresses)
	// ****************************************
	localparam logic [1:0] ADDR_CTRL = 2'h0;
	localparam logic [1:0] ADDR_STAT = 2'h1;
	localparam logic [1:0] ADDR_MASK = 2'h2;
	localparam logic [1:0] ADDR_PHASE = 2'h3;
	localparam logic [11:0] CTRL_RST = 12'h000;
	// control field positions
	localparam int B_SENSOR = 0;
	localparam int B_VC = 1;
	localparam int B_EDGE = 2;
	localparam int B_POL = 3;
	localparam int B_GRP = 4;
	localparam int B_CFG = 5;
	localparam int B_INSEL = 8;
	localparam int B_HDM = 10;
	localparam int B_SDM = 11;
	// status / mask bit positions
	localparam int S_ZC = 0;
	localparam int S_DEMAG = 1;
	// output configuration low-bit codes
	localparam logic [1:0] CFG_EVEN = 2'h0;
	localparam logic [1:0] CFG_ODD = 2'h1;
	localparam logic [1:0] CFG_ALT = 2'h2;
	localparam logic [1:0] CFG_BOTH = 2'h3;
	localparam logic [2:0] CFG_V_ALT = 3'h6;
	// event stages, gray coded along C -> D -> Z
	typedef enum logic [1:0] {
		STG_WAIT_C = 2'h0,
		STG_DEMAG = 2'h1,
		STG_ZC = 2'h3
	} stage_t;
endpackage

// [bench/phase_model.sv]
// far-side model: motor phase comparator output and three rotor sensors
`timescale 1ns/1ns
module phase_model (
	// clock
	input wire logic clk_sys,
	// levels asked for by the bench
	input wire logic cmp_lvl,
	input wire logic [2:0] hall_lvl,
	// pins into the block
	output logic cmp_in,
	output logic phase_in_a,
	output logic phase_in_b,
	output logic phase_in_c
);
	// ****************************************
	// pin drivers
	// ****************************************
	// known levels from time zero
	initial begin
		cmp_in = 1'h1;
		{phase_in_c, phase_in_b, phase_in_a} = 3'h0;
	end
	// pins follow the bench levels one clock later
	always @(posedge clk_sys) begin
		cmp_in <= cmp_lvl;
		{phase_in_c, phase_in_b, phase_in_a} <= hall_lvl; // sensors as logic levels
	end
endmodule // phase_model

// [bench/bemf_zc_qualifier_tb.sv]
// self-checking testbench of the zero-crossing qualifier
`timescale 1ns/1ns
module bemf_zc_qualifier_tb
	import bemf_pkg::*;
;
	// ****************************************
	// signals
	// ****************************************
	logic clk_sys = 1'h0;
	logic rst = 1'h1;
	logic [1:0] avs_address = 2'h0;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, zc_trigger, demag_trigger, zc_sampling, demag_enable, irq;
	logic [2:0] pwm_cfg_eff;
	logic [2:0] hall_lvl = 3'h0;
	logic [5:0] min_off_cyc;
	logic phase_in_a, phase_in_b, phase_in_c, cmp_in;
	logic cmp_lvl = 1'h1;
	logic commutation_evt = 1'h0;
	logic sw_demag_evt = 1'h0;
	logic pwm_on_even = 1'h1;
	logic pwm_on_odd = 1'h1;
	logic direct_access = 1'h0;
	int n_fail = 0;
	int n_tests = 0;
	int n_zc = 0;
	int n_dm = 0;
	int cyc = 0;
	// ****************************************
	// design and far side
	// ****************************************
	bemf_zc_qualifier u_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.phase_in_a(phase_in_a), .phase_in_b(phase_in_b), .phase_in_c(phase_in_c),
		.cmp_in(cmp_in), .commutation_evt(commutation_evt), .sw_demag_evt(sw_demag_evt),
		.pwm_on_even(pwm_on_even), .pwm_on_odd(pwm_on_odd), .direct_access(direct_access),
		.zc_trigger(zc_trigger), .demag_trigger(demag_trigger), .zc_sampling(zc_sampling),
		.demag_enable(demag_enable), .pwm_cfg_eff(pwm_cfg_eff), .min_off_cyc(min_off_cyc),
		.irq(irq));
	phase_model u_model (.clk_sys(clk_sys), .cmp_lvl(cmp_lvl), .hall_lvl(hall_lvl),
		.cmp_in(cmp_in), .phase_in_a(phase_in_a), .phase_in_b(phase_in_b),
		.phase_in_c(phase_in_c));
	// 25 MHz clock
	always #20 clk_sys = ~clk_sys;
	// ****************************************
	// helpers
	// ****************************************
	task automatic end_sim();
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic clocks(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		// waitrequest is judged at each rising edge; no per-transfer limit, only the bench timeout ends a hang
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'h0);
		q = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
	endtask
	task automatic wait_for(ref int cnt, input int v);
		for (int k = 0; k < 300 && cnt < v; k++) @(posedge clk_sys);
	endtask
	task automatic commutate();
		@(posedge clk_sys);
		commutation_evt <= 1'h1;
		@(posedge clk_sys);
		commutation_evt <= 1'h0;
	endtask
	// one-cycle software demagnetization pulse
	task automatic sw_demag();
		@(posedge clk_sys);
		sw_demag_evt <= 1'h1;
		@(posedge clk_sys);
		sw_demag_evt <= 1'h0;
	endtask
	function automatic logic [31:0] mkc(input logic s, v, e, p, g, input logic [2:0] c,
		input logic [1:0] is, input logic h);
		logic [31:0] r;
		r = 32'h0;
		r[B_SENSOR] = s;
		r[B_VC] = v;
		r[B_EDGE] = e;
		r[B_POL] = p;
		r[B_GRP] = g;
		r[B_CFG+:3] = c;
		r[B_INSEL+:2] = is;
		r[B_HDM] = h;
		return r;
	endfunction
	// sensorless read permission from mode, output config, group select and pwm groups
	function automatic logic ok_exp(input logic v, input logic [2:0] c, input logic g, e, o);
		if (c[1:0] == CFG_BOTH) return e | o;
		if (c[1:0] == CFG_ALT) return (v || c == CFG_V_ALT) ? (g ? o : e) : 1'h0;
		return (c[0] == g) ? (g ? o : e) : 1'h0;
	endfunction
	// count trigger pulses and cut a hang short
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (zc_trigger === 1'h1) n_zc <= n_zc + 1;
		if (demag_trigger === 1'h1) n_dm <= n_dm + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			end_sim();
		end
	end
	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		clocks(3);
		rst <= 1'h0;
		clocks(4);
		bus(0, ADDR_CTRL, 32'h0, rd);
		chk(rd, {20'h0, CTRL_RST});
		bus(0, ADDR_MASK, 32'h0, rd);
		chk(rd, 32'h0);
		bus(1, ADDR_CTRL, 32'hFFFFFFFF, rd);
		bus(0, ADDR_CTRL, 32'h0, rd);
		chk(rd, 32'h00000FFF);
		chk(pwm_cfg_eff, 32'h3);
		chk(min_off_cyc, MIN_OFF_SENSOR_CYC);
		chk(demag_enable, 32'h0);
		// permission table, both groups driven
		for (int i = 0; i < 32; i++) begin
			bus(1, ADDR_CTRL, mkc(0, i[4], 0, 0, i[0], i[3:1], 2'h0, 0), rd);
			bus(0, ADDR_PHASE, 32'h0, rd);
			chk(rd[3], ok_exp(i[4], i[3:1], i[0], 1'h1, 1'h1));
		end
		chk(min_off_cyc, MIN_OFF_NORM_CYC);
		chk(demag_enable, 32'h1);
		chk(pwm_cfg_eff, 32'h7);
		pwm_on_odd <= 1'h0;
		bus(1, ADDR_CTRL, mkc(0, 1, 0, 0, 1, 3'h1, 2'h0, 0), rd);
		bus(0, ADDR_PHASE, 32'h0, rd);
		chk(rd[3], 32'h0);
		bus(1, ADDR_CTRL, mkc(0, 1, 0, 0, 0, 3'h0, 2'h0, 0), rd);
		bus(0, ADDR_PHASE, 32'h0, rd);
		chk(rd[3], 32'h1);
		// sensor mode permits reading with no pwm group at all
		pwm_on_even <= 1'h0;
		bus(1, ADDR_CTRL, mkc(1, 0, 0, 0, 0, 3'h2, 2'h0, 0), rd);
		bus(0, ADDR_PHASE, 32'h0, rd);
		chk(rd[3], 32'h1);
		// sensorless: C, spurious edges, D, filtered Z, forbidden Z, real Z
		pwm_on_even <= 1'h1;
		bus(1, ADDR_CTRL, mkc(0, 1, 0, 0, 0, 3'h0, 2'h0, 1), rd);
		bus(1, ADDR_MASK, 32'h1, rd);
		commutate();
		bus(0, ADDR_PHASE, 32'h0, rd);
		chk(rd[2:1], STG_DEMAG);
		clocks(100);
		cmp_lvl <= 1'h0;
		clocks(200);
		cmp_lvl <= 1'h1;
		clocks(500);
		chk(n_dm, 0);
		chk(n_zc, 0);
		cmp_lvl <= 1'h0;
		wait_for(n_dm, 1);
		chk(n_dm, 1);
		bus(0, ADDR_PHASE, 32'h0, rd);
		chk(rd[2:1], STG_ZC);
		chk(zc_sampling, 32'h1);
		clocks(100);
		cmp_lvl <= 1'h1;
		clocks(200);
		cmp_lvl <= 1'h0;
		clocks(300);
		pwm_on_even <= 1'h0;
		clocks(10);
		cmp_lvl <= 1'h1;
		clocks(100);
		chk(n_zc, 0);
		cmp_lvl <= 1'h0;
		clocks(100);
		pwm_on_even <= 1'h1;
		clocks(10);
		cmp_lvl <= 1'h1;
		wait_for(n_zc, 1);
		chk(n_zc, 1);
		bus(0, ADDR_STAT, 32'h0, rd);
		chk(rd[S_ZC], 32'h1);
		chk(irq, 32'h1);
		bus(0, ADDR_PHASE, 32'h0, rd);
		chk(rd[2:1], STG_WAIT_C);
		bus(1, ADDR_STAT, 32'h1, rd);
		clocks(1);
		chk(irq, 32'h0);
		// sensorless software demagnetization: one pulse inside the filter, one after it
		bus(1, ADDR_CTRL, mkc(0, 1, 0, 0, 0, 3'h0, 2'h0, 0) | (32'h1 << B_SDM), rd);
		commutate();
		clocks(100);
		sw_demag();
		clocks(700);
		chk(n_dm, 1);
		sw_demag();
		wait_for(n_dm, 2);
		chk(n_dm, 2);
		// sensor mode: input B selected, inverted polarity, falling-edge select
		bus(1, ADDR_MASK, 32'h0, rd);
		pwm_on_even <= 1'h0;
		bus(1, ADDR_CTRL, mkc(1, 0, 1, 1, 0, 3'h7, 2'h1, 1) | (32'h1 << B_SDM), rd);
		commutate();
		bus(0, ADDR_PHASE, 32'h0, rd);
		chk(rd[2:1], STG_ZC);
		clocks(600);
		sw_demag();
		hall_lvl <= 3'h1;
		clocks(100);
		chk(n_zc, 1);
		hall_lvl <= 3'h3;
		wait_for(n_zc, 2);
		chk(n_zc, 2);
		chk(irq, 32'h0);
		bus(1, ADDR_MASK, 32'h1, rd);
		clocks(1);
		chk(irq, 32'h1);
		chk(n_dm, 2);
		// latched sample of input C in direct access, then refreshed by the access toggle
		hall_lvl <= 3'h4;
		bus(1, ADDR_CTRL, mkc(1, 0, 0, 0, 0, 3'h0, 2'h2, 0), rd);
		clocks(100);
		direct_access <= 1'h1;
		hall_lvl <= 3'h0;
		clocks(100);
		bus(0, ADDR_PHASE, 32'h0, rd);
		chk(rd[0], 32'h1);
		direct_access <= 1'h0;
		clocks(100);
		direct_access <= 1'h1;
		clocks(5);
		bus(0, ADDR_PHASE, 32'h0, rd);
		chk(rd[0], 32'h0);
		end_sim();
	end
endmodule // bemf_zc_qualifier_tb
